// File: logic/aso_defines.svh
`ifndef ASO_DEFINES_SVH
`define ASO_DEFINES_SVH
// result word and serial framing
`define ASO_RESULT_BITS      14
`define ASO_SERIAL_BITS      16
`define ASO_PAR_BITS         12
// internal conversion clock divider: serial clock half period in sys_clk cycles
`define ASO_SCLK_HALF_NS     160
`define ASO_SYS_CLK_NS       20
`define ASO_SCLK_HALF_CYC    (`ASO_SCLK_HALF_NS / `ASO_SYS_CLK_NS)
// acquisition time before the first bit is shifted
`define ASO_ACQ_NS           400
`define ASO_ACQ_CYC          ((`ASO_ACQ_NS + `ASO_SYS_CLK_NS - 1) / `ASO_SYS_CLK_NS)
`endif

// File: logic/aso_pkg.sv
package aso_pkg;
    // serial link pins, each three-state output line split in value and enable
    typedef struct packed {
        logic sclk_o;
        logic sclk_oe;
        logic data_o;
        logic data_oe;
        logic strobe_o;
        logic strobe_oe;
    } aso_serial_type;
    typedef enum logic [1:0] {
        ASO_IDLE,
        ASO_ACQ,
        ASO_SHIFT,
        ASO_DONE
    } aso_state_type;
endpackage

// File: logic/aso_converter_out.sv
`timescale 1ns/100ps
`include "aso_defines.svh"
// Contract
// [RQ1] clock-format input low selects gated serial clock, pulses only while shifting
// [RQ2] gated mode: data bit valid before the first falling serial clock edge
// [RQ3] serial clock and data lines released whenever no conversion runs
// [RQ4] result bits are driven during conversion, not afterwards
// [RQ5] receiver takes our clock as input, 16-bit words, frame sync length zero
// [RQ6] continuous mode: strobe marks valid data, receiver inverts it
// [RQ7] free-running-clock receivers only with continuous clock mode
// [RQ8] receiver collects 16 bits then interrupts its software
// [RQ9] standalone parallel mode: conversion starts from a chip-select pulse
// [RQ10] chip-select pulse held longer than the full conversion time
// [RQ11] busy low enables parallel outputs; busy wired to read input
// [RQ12] external latch captures parallel data on busy rising edge
// [RQ13] clock-format high runs serial clock continuously, low gates it
// [RQ14] host does not read while a conversion is in progress
module aso_converter_out
    import aso_pkg::*;
#(
    parameter int RESULT_BITS = `ASO_RESULT_BITS,
    parameter int SERIAL_BITS = `ASO_SERIAL_BITS,
    parameter int PAR_BITS    = `ASO_PAR_BITS
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    // conversion control pins (asynchronous)
    input  wire logic                   conversion_start_n,
    input  wire logic                   chip_select_n,
    input  wire logic                   continuous_clock_sel,
    input  wire logic                   parallel_mode_sel,
    input  wire logic                   read_n,
    // sample value from the converter core
    input  wire logic [RESULT_BITS-1:0] sample_value,
    // serial link
    output aso_serial_type              serial_link,
    // parallel output and busy
    output logic [PAR_BITS-1:0]         parallel_data_bits,
    output logic                        parallel_data_oe,
    output logic                        busy_n
);
    // elaboration check: the shifter is a fixed 16-bit register
    if (SERIAL_BITS < RESULT_BITS || SERIAL_BITS > 16 || PAR_BITS > RESULT_BITS
        || RESULT_BITS > 16) begin : g_bad_widths
        $error("aso_converter_out: unsupported widths");
    end

    localparam logic [3:0] HALF_CYC = 4'(`ASO_SCLK_HALF_CYC);
    localparam logic [4:0] ACQ_CYC  = 5'(`ASO_ACQ_CYC);
    localparam logic [4:0] NBITS    = 5'(SERIAL_BITS);

    // two-flop synchronisers for pins
    logic [4:0] sync1_q, sync2_q, sync1_d, sync2_d;
    logic       cstart_prev_q, cstart_prev_d;
    logic       cs_s, cont_s, par_s, rd_s, start_lvl, start_fall;
    always_comb begin
        sync1_d = {read_n, parallel_mode_sel, continuous_clock_sel, chip_select_n,
                   conversion_start_n};
        sync2_d = sync1_q;
        // edge detector must remember the same level that it compares
        cstart_prev_d = start_lvl;
    end
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sync1_q       <= 5'h1F;
            sync2_q       <= 5'h1F;
            cstart_prev_q <= 1'b1;
        end else begin
            sync1_q       <= sync1_d;
            sync2_q       <= sync2_d;
            cstart_prev_q <= cstart_prev_d;
        end
    end
    assign cs_s       = sync2_q[1];
    assign cont_s     = sync2_q[2];
    assign par_s      = sync2_q[3];
    assign rd_s       = sync2_q[4];
    // parallel mode starts from chip select; serial needs start and select both low
    assign start_lvl  = par_s ? cs_s : (sync2_q[0] | cs_s); // RQ9
    assign start_fall = cstart_prev_q & ~start_lvl;

    // conversion sequencer and serial shifter
    aso_state_type         state_q, state_d;
    logic [4:0]            cnt_q, cnt_d;
    logic [3:0]            div_q, div_d;
    logic                  sclk_q, sclk_d;
    logic [15:0]           shreg_q, shreg_d;
    logic [RESULT_BITS-1:0] result_q, result_d;
    logic                  free_q, free_d;
    logic                  busy_n_q, busy_n_d;
    logic                  half_tick;
    assign half_tick = (div_q == HALF_CYC - 4'h1);

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        div_d    = half_tick ? 4'h0 : div_q + 4'h1;
        sclk_d   = sclk_q;
        shreg_d  = shreg_q;
        result_d = result_q;
        free_d   = free_q;
        busy_n_d = busy_n_q;
        // free-running clock toggles in continuous mode at all times
        if (half_tick)
            free_d = ~free_q; // RQ13
        case (state_q)
            ASO_IDLE: begin
                sclk_d = 1'b1;
                if (start_fall) begin
                    state_d  = ASO_ACQ;
                    cnt_d    = ACQ_CYC;
                    busy_n_d = 1'b0;
                    // sign extended result, msb first
                    shreg_d  = 16'($signed(sample_value)) << (16 - SERIAL_BITS);
                end
            end
            ASO_ACQ: begin
                if (cnt_q > 5'h1)
                    cnt_d = cnt_q - 5'h1;
                // continuous: enter as the free clock rises, so its falls meet settled bits
                else if (half_tick && (!cont_s || !free_q)) begin
                    // first bit is already on the line before any falling edge
                    state_d = ASO_SHIFT; // RQ2
                    cnt_d   = NBITS;
                    sclk_d  = 1'b1;
                end
            end
            ASO_SHIFT: begin
                if (half_tick) begin
                    sclk_d = ~sclk_q;
                    // rising edge moves the next bit out, receiver samples on falling
                    if (!sclk_q) begin
                        shreg_d = {shreg_q[14:0], 1'b0};
                        cnt_d   = cnt_q - 5'h1;
                        if (cnt_q == 5'h1) begin
                            state_d  = ASO_DONE;
                            result_d = sample_value;
                        end
                    end
                end
            end
            ASO_DONE: begin
                // busy rising edge ends conversion; data stable for the latch
                busy_n_d = 1'b1; // RQ12
                state_d  = ASO_IDLE;
            end
            default: state_d = ASO_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q  <= ASO_IDLE;
            cnt_q    <= 5'h00;
            div_q    <= 4'h0;
            sclk_q   <= 1'b1;
            shreg_q  <= 16'h0000;
            result_q <= '0;
            free_q   <= 1'b1;
            busy_n_q <= 1'b1;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            div_q    <= div_d;
            sclk_q   <= sclk_d;
            shreg_q  <= shreg_d;
            result_q <= result_d;
            free_q   <= free_d;
            busy_n_q <= busy_n_d;
        end
    end

    // pin drivers, all registered
    aso_serial_type link_d, link_q;
    logic [PAR_BITS-1:0] par_d, par_q;
    logic                par_oe_d, par_oe_q;
    logic                converting;
    assign converting = (state_q == ASO_ACQ) || (state_q == ASO_SHIFT);
    always_comb begin
        // lines float outside conversion
        link_d.sclk_oe   = converting & ~par_s; // RQ3
        link_d.data_oe   = converting & ~par_s; // RQ3
        link_d.strobe_oe = converting & ~par_s;
        // gated clock only pulses while shifting; continuous follows free clock
        link_d.sclk_o    = cont_s ? free_d : sclk_d; // RQ1 RQ13
        // data driven during the conversion itself
        link_d.data_o    = shreg_d[15]; // RQ4
        // strobe low while valid bits shift, receiver inverts it
        link_d.strobe_o  = ~(state_d == ASO_SHIFT); // RQ6
        // read low in parallel mode opens the parallel bus
        par_oe_d = par_s & ~rd_s; // RQ11
        par_d    = result_d[RESULT_BITS-1 -: PAR_BITS];
    end
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            link_q   <= '{sclk_o: 1'b1, sclk_oe: 1'b0, data_o: 1'b0, data_oe: 1'b0,
                          strobe_o: 1'b1, strobe_oe: 1'b0};
            par_q    <= '0;
            par_oe_q <= 1'b0;
        end else begin
            link_q   <= link_d;
            par_q    <= par_d;
            par_oe_q <= par_oe_d;
        end
    end
    assign serial_link        = link_q;
    assign parallel_data_bits = par_q;
    assign parallel_data_oe   = par_oe_q;
    assign busy_n             = busy_n_q;

    // assertions
    a_lines_float: assert property (@(posedge sys_clk) disable iff (!rstn) // RQ3
        (state_q == ASO_IDLE) |=> !serial_link.sclk_oe && !serial_link.data_oe)
        else $error("serial lines driven while idle");
    a_gated_quiet: assert property (@(posedge sys_clk) disable iff (!rstn) // RQ1
        (state_q == ASO_ACQ && !cont_s) |=> serial_link.sclk_o)
        else $error("gated clock pulsed outside shifting");
    a_start_busy: assert property (@(posedge sys_clk) disable iff (!rstn) // RQ9
        (state_q == ASO_IDLE && start_fall) |=> !busy_n ##1 serial_link.data_oe == !par_s)
        else $error("start did not begin conversion");
    a_data_in_conv: assert property (@(posedge sys_clk) disable iff (!rstn) // RQ4
        serial_link.data_oe |-> !busy_n)
        else $error("data driven after conversion");
    a_busy_end: assert property (@(posedge sys_clk) disable iff (!rstn) // RQ12
        (state_q == ASO_DONE) |=> busy_n && $rose(busy_n))
        else $error("busy did not rise at end");
    a_strobe_shift: assert property (@(posedge sys_clk) disable iff (!rstn) // RQ6
        (state_q == ASO_SHIFT) |=> !serial_link.strobe_o || state_q != ASO_SHIFT)
        else $error("strobe not marking shift");
    a_first_bit: assert property (@(posedge sys_clk) disable iff (!rstn) // RQ2
        $rose(state_q == ASO_SHIFT) |-> serial_link.sclk_o)
        else $error("clock low before first bit");
    a_par_enable: assert property (@(posedge sys_clk) disable iff (!rstn) // RQ11
        parallel_data_oe |-> $past(par_s))
        else $error("parallel bus enabled outside parallel mode");
endmodule

// File: verif/aso_dsp_port.sv
`timescale 1ns/100ps
// receiving serial port of the signal processor, clock taken as an input
module aso_dsp_port (
    // link wires as seen at the pins
    input  wire logic        sclk_w,
    input  wire logic        data_w,
    input  wire logic        strobe_w,
    // port setup
    input  wire logic        cont_mode,
    input  wire logic        clear,
    // received word
    output logic [15:0]      rx_word,
    output logic [7:0]       rx_bits,
    output logic             rx_irq
);
    // bits taken on falling clock edges, no frame pulse needed when gated
    always @(negedge sclk_w or posedge clear) begin
        if (clear) begin
            rx_word <= 16'h0000;
            rx_bits <= 8'h00;
        end else if (!cont_mode || !strobe_w) begin
            rx_word <= {rx_word[14:0], data_w};
            rx_bits <= rx_bits + 8'h01;
        end
    end
    // interrupt once a whole word is in
    assign rx_irq = (rx_bits == 8'h10);
endmodule

// File: verif/aso_converter_out_tb_top.sv
`timescale 1ns/100ps
module aso_converter_out_tb_top;
    import aso_pkg::*;
    logic           sys_clk = 1'b0;
    logic           rstn = 1'b0;
    logic           conversion_start_n = 1'b1;
    logic           chip_select_n = 1'b1;
    logic           continuous_clock_sel = 1'b0;
    logic           parallel_mode_sel = 1'b0;
    logic [13:0]    sample_value = 14'h0000;
    logic           clear = 1'b1;
    aso_serial_type serial_link;
    logic [11:0]    parallel_data_bits;
    logic [11:0]    latch_q;
    logic           parallel_data_oe;
    logic           busy_n;
    logic [15:0]    rx_word;
    logic [7:0]     rx_bits;
    logic           rx_irq;
    int             bad_count = 0;
    int             samples_checked = 0;
    int             cycles = 0;
    // released lines float up through the board pull-ups
    wire logic sclk_w = serial_link.sclk_oe ? serial_link.sclk_o : 1'b1;
    wire logic data_w = serial_link.data_oe ? serial_link.data_o : 1'b1;
    wire logic strb_w = serial_link.strobe_oe ? serial_link.strobe_o : 1'b1;
    // standalone ties busy to read; serial host never reads during conversion
    wire logic read_n = parallel_mode_sel ? busy_n : 1'b1;

    always #10 sys_clk = ~sys_clk;

    aso_converter_out dut_u (.sys_clk(sys_clk), .rstn(rstn),
        .conversion_start_n(conversion_start_n), .chip_select_n(chip_select_n),
        .continuous_clock_sel(continuous_clock_sel), .parallel_mode_sel(parallel_mode_sel),
        .read_n(read_n), .sample_value(sample_value), .serial_link(serial_link),
        .parallel_data_bits(parallel_data_bits), .parallel_data_oe(parallel_data_oe),
        .busy_n(busy_n));
    aso_dsp_port port_u (.sclk_w(sclk_w), .data_w(data_w), .strobe_w(strb_w),
        .cont_mode(continuous_clock_sel), .clear(clear), .rx_word(rx_word),
        .rx_bits(rx_bits), .rx_irq(rx_irq));

    // external latch closes on the end of conversion
    always @(posedge busy_n) latch_q <= parallel_data_bits;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // a hang is cut short and judged as a mismatch
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one conversion; the start pin stays low past the busy rise
    task automatic convert(input logic par, input logic cont, input logic [13:0] val);
        int n;
        @(posedge sys_clk);
        parallel_mode_sel <= par;
        continuous_clock_sel <= cont;
        sample_value <= val;
        clear <= 1'b1;
        chip_select_n <= par;
        repeat (4) @(posedge sys_clk);
        clear <= 1'b0;
        if (par) chip_select_n <= 1'b0;
        else conversion_start_n <= 1'b0;
        n = 0;
        do begin @(negedge sys_clk); n++; end while (busy_n !== 1'b0 && n < 10);
        repeat (5) @(negedge sys_clk);
        check("serial data enable", serial_link.data_oe, !par);
        check("parallel enable", parallel_data_oe, par);
        n = 0;
        do begin @(negedge sys_clk); n++; end while (busy_n !== 1'b1 && n < 600);
        check("busy end", busy_n, 1'b1);
        @(posedge sys_clk);
        chip_select_n <= 1'b1;
        conversion_start_n <= 1'b1;
        repeat (3) @(negedge sys_clk);
        check("clock enable idle", serial_link.sclk_oe, 1'b0);
        check("data enable idle", serial_link.data_oe, 1'b0);
    endtask
    // serial word, sign bits first, both clock formats
    task automatic test_serial(input logic cont, input logic [13:0] val);
        convert(1'b0, cont, val);
        check("serial word", rx_word, {{2{val[13]}}, val});
        check("bit count", rx_bits, 16'h0010);
        check("word interrupt", rx_irq, 1'b1);
        $display("test serial mode %0d done", cont);
    endtask
    // standalone parallel conversion, serial lines silent
    task automatic test_parallel(input logic [13:0] val);
        convert(1'b1, 1'b0, val);
        check("latched data", latch_q, val[13:2]);
        check("serial silent", rx_bits, 16'h0000);
        $display("test parallel done");
    endtask

    // lines released and busy idle after reset
    task automatic test_reset();
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(negedge sys_clk);
        check("busy after reset", busy_n, 1'b1);
        check("clock enable reset", serial_link.sclk_oe, 1'b0);
        check("data enable reset", serial_link.data_oe, 1'b0);
        $display("test reset done");
    endtask

    initial begin
        test_reset();
        test_serial(1'b0, 14'h2ABC);
        test_serial(1'b0, 14'h1FFF);
        test_serial(1'b1, 14'h2000);
        test_serial(1'b1, 14'h1234);
        test_parallel(14'h2ABC);
        end_of_test();
    end
endmodule
